// ---- fifo_flag_width_expansion.sv ----
// FIFO with active-low status flags, offset programming and a register port.
// Write and read clocks arrive as pins and are sampled by i_clk, so each
// pin clock must stay high and low for at least two i_clk periods.
//
// Summary of operation
// - Load select low at reset: offset mode
// - Full flag low when all locations hold
// - Writes ignored while full flag low
// - Full flag changes only on write clock
// - Empty flag low when no words remain
// - Reads ignored while empty flag low
// - Empty flag changes only on read clock
// - Almost-empty offset defaults to seven
// - Almost-full offset defaults to seven
// - Almost-empty low at n or fewer
// - Almost-full low at depth minus m
// - Load select high at reset: second enable
// - Load writes walk four offset parts, wrap
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module fifo_flag_width_expansion
  import fifo_flag_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEFAULT,
  parameter int ADDR_W = ADDR_W_DEFAULT
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Write port pins
  input wire logic i_write_clock,
  input wire logic i_write_enable_primary_n,
  input wire logic i_write_enable_load_select,
  input wire logic [DATA_W-1:0] i_write_data,
  // Read port pins
  input wire logic i_read_clock,
  input wire logic i_read_enable_primary_n,
  input wire logic i_read_enable_secondary_n,
  output logic [DATA_W-1:0] o_read_data,
  // Status flag pins, active low
  output logic o_full_flag_n,
  output logic o_empty_flag_n,
  output logic o_almost_full_flag_n,
  output logic o_almost_empty_flag_n,
  // Register port
  input wire logic [BUS_AW-1:0] i_addr,
  input wire logic [BUS_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [BUS_DW-1:0] o_rdata,
  // Interrupt
  output logic o_irq
);

  localparam int CNT_W = ADDR_W + 1;
  localparam int HI_W = ADDR_W - OFFSET_LSB_W;
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam logic [ADDR_W-1:0] OFFSET_RESET = ADDR_W'(OFFSET_DEFAULT);

  // Pin synchroniser: all pins travel together so data stays aligned to its clock
  pin_in_t pins_raw;
  pin_in_t sync1_q;
  pin_in_t sync2_q;
  pin_in_t sync3_q;

  assign pins_raw = '{
    write_clock: i_write_clock,
    write_enable_primary_n: i_write_enable_primary_n,
    write_enable_load_select: i_write_enable_load_select,
    read_clock: i_read_clock,
    read_enable_primary_n: i_read_enable_primary_n,
    read_enable_secondary_n: i_read_enable_secondary_n,
    write_data: i_write_data
  };

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Mode capture while the synchroniser fills after reset release
  logic [1:0] fill_q;
  logic ready_q;
  logic load_mode_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fill_q <= '0;
      ready_q <= 1'b0;
      load_mode_q <= 1'b0;
    end else if (!ready_q) begin
      fill_q <= fill_q + 2'h1;
      ready_q <= (fill_q == SYNC_FILL);
      load_mode_q <= ~sync2_q.write_enable_load_select;
    end
  end

  // Pin clock edges; reads and writes are not taken before the mode is known
  logic wr_edge;
  logic rd_edge;
  assign wr_edge = ready_q & sync2_q.write_clock & ~sync3_q.write_clock;
  assign rd_edge = ready_q & sync2_q.read_clock & ~sync3_q.read_clock;

  logic wen_low;
  logic ren_low;
  logic wr_req;
  logic prog_wr;
  logic rd_req;
  logic prog_rd;
  assign wen_low = ~sync2_q.write_enable_primary_n;
  assign ren_low = ~sync2_q.read_enable_primary_n & ~sync2_q.read_enable_secondary_n;
  // Same pin levels write the array in either mode
  assign wr_req = wr_edge & wen_low & sync2_q.write_enable_load_select;
  assign prog_wr = wr_edge & load_mode_q & wen_low & ~sync2_q.write_enable_load_select;
  assign rd_req = rd_edge & ren_low & ~(load_mode_q & ~sync2_q.write_enable_load_select);
  assign prog_rd = rd_edge & ren_low & load_mode_q & ~sync2_q.write_enable_load_select;

  flags_t flags_q;
  flags_t flags_d;
  logic [CNT_W-1:0] count_q;
  logic [ADDR_W-1:0] wptr_q;
  logic [ADDR_W-1:0] rptr_q;
  logic [ADDR_W-1:0] n_q;
  logic [ADDR_W-1:0] m_q;
  offset_part_t part_q;

  logic wr_do;
  logic rd_do;
  assign wr_do = wr_req & flags_q.full_n;
  assign rd_do = rd_req & flags_q.empty_n;

  logic [CNT_W-1:0] count_d;
  assign count_d = count_q + {{ADDR_W{1'b0}}, wr_do} - {{ADDR_W{1'b0}}, rd_do};

  // Each flag follows the count only on its own clock's edges
  always_comb begin
    flags_d = flags_q;
    if (wr_edge) begin
      flags_d.full_n = (count_d != DEPTH_C);
      flags_d.almost_full_n = (count_d < (DEPTH_C - {1'b0, m_q}));
    end
    if (rd_edge) begin
      flags_d.empty_n = (count_d != '0);
      flags_d.almost_empty_n = (count_d > {1'b0, n_q});
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flags_q <= FLAGS_RESET;
      count_q <= '0;
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      flags_q <= flags_d;
      count_q <= count_d;
      wptr_q <= wptr_q + ADDR_W'(wr_do);
      rptr_q <= rptr_q + ADDR_W'(rd_do);
    end
  end

  // Offset registers; one pointer is shared by load writes and load reads
  logic [ADDR_W-1:0] n_d;
  logic [ADDR_W-1:0] m_d;
  logic [DATA_W-1:0] wdat;
  assign wdat = sync2_q.write_data;

  always_comb begin
    n_d = n_q;
    m_d = m_q;
    if (prog_wr) begin
      unique case (part_q)
        PART_EMPTY_LO: n_d[OFFSET_LSB_W-1:0] = wdat;
        PART_EMPTY_HI: n_d[ADDR_W-1:OFFSET_LSB_W] = wdat[HI_W-1:0];
        PART_FULL_LO: m_d[OFFSET_LSB_W-1:0] = wdat;
        PART_FULL_HI: m_d[ADDR_W-1:OFFSET_LSB_W] = wdat[HI_W-1:0];
      endcase
    end
  end

  logic [DATA_W-1:0] part_value;
  always_comb begin
    unique case (part_q)
      PART_EMPTY_LO: part_value = n_q[OFFSET_LSB_W-1:0];
      PART_EMPTY_HI: part_value = DATA_W'(n_q[ADDR_W-1:OFFSET_LSB_W]);
      PART_FULL_LO: part_value = m_q[OFFSET_LSB_W-1:0];
      PART_FULL_HI: part_value = DATA_W'(m_q[ADDR_W-1:OFFSET_LSB_W]);
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      n_q <= OFFSET_RESET;
      m_q <= OFFSET_RESET;
      part_q <= PART_EMPTY_LO;
    end else begin
      n_q <= n_d;
      m_q <= m_d;
      if (prog_wr || prog_rd) begin
        part_q <= offset_part_t'(part_q + 2'h1);
      end
    end
  end

  // Storage and read data path
  logic [DATA_W-1:0] mem_rdata;
  logic rd_pend_q;
  logic [DATA_W-1:0] rd_data_q;

  fifo_store #(
    .DEPTH(DEPTH),
    .ADDR_W(ADDR_W)
  ) u_store (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_wr_en(wr_do),
    .i_wr_addr(wptr_q),
    .i_wr_data(wdat),
    .i_rd_en(rd_do),
    .i_rd_addr(rptr_q),
    .o_rd_data(mem_rdata)
  );

  // A refused read leaves the last word standing on the output
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_pend_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      rd_pend_q <= rd_do;
      if (rd_pend_q) begin
        rd_data_q <= mem_rdata;
      end else if (prog_rd) begin
        rd_data_q <= part_value;
      end
    end
  end

  assign o_read_data = rd_data_q;
  assign o_full_flag_n = flags_q.full_n;
  assign o_empty_flag_n = flags_q.empty_n;
  assign o_almost_full_flag_n = flags_q.almost_full_n;
  assign o_almost_empty_flag_n = flags_q.almost_empty_n;

  // Events: a flag falling, or a request refused by a flag
  logic [EVT_W-1:0] events;
  assign events[EVT_FULL] = flags_q.full_n & ~flags_d.full_n;
  assign events[EVT_EMPTY] = flags_q.empty_n & ~flags_d.empty_n;
  assign events[EVT_ALMOST_FULL] = flags_q.almost_full_n & ~flags_d.almost_full_n;
  assign events[EVT_ALMOST_EMPTY] = flags_q.almost_empty_n & ~flags_d.almost_empty_n;
  assign events[EVT_WR_REFUSED] = wr_req & ~flags_q.full_n;
  assign events[EVT_RD_REFUSED] = rd_req & ~flags_q.empty_n;

  // Register port
  logic sel_status;
  logic sel_mask;
  logic sel_flags;
  logic sel_level;
  logic sel_offsets;
  assign sel_status = (i_addr == REG_STATUS);
  assign sel_mask = (i_addr == REG_MASK);
  assign sel_flags = (i_addr == REG_FLAGS);
  assign sel_level = (i_addr == REG_LEVEL);
  assign sel_offsets = (i_addr == REG_OFFSETS);

  logic [EVT_W-1:0] status_q;
  logic [EVT_W-1:0] mask_q;
  logic [EVT_W-1:0] status_clr;
  logic [EVT_W-1:0] status_d;
  assign status_clr = (i_wr && sel_status) ? i_wdata[EVT_W-1:0] : '0;
  // Set wins over a clear arriving in the same cycle
  assign status_d = (status_q & ~status_clr) | events;

  logic [BUS_DW-1:0] flags_word;
  logic [BUS_DW-1:0] offsets_word;
  assign flags_word = BUS_DW'({load_mode_q, flags_q.almost_empty_n,
    flags_q.almost_full_n, flags_q.empty_n, flags_q.full_n});
  assign offsets_word = (BUS_DW'(n_q) << OFFS_N_LSB) | (BUS_DW'(m_q) << OFFS_M_LSB);

  logic [BUS_DW-1:0] rdata_mux;
  assign rdata_mux = sel_status ? BUS_DW'(status_q) :
                     sel_mask ? BUS_DW'(mask_q) :
                     sel_flags ? flags_word :
                     sel_level ? BUS_DW'(count_q) :
                     sel_offsets ? offsets_word : '0;

  logic [BUS_DW-1:0] rdata_q;
  logic irq_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status_q <= '0;
      mask_q <= MASK_RESET;
      rdata_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      if (i_wr && sel_mask) begin
        mask_q <= i_wdata[EVT_W-1:0];
      end
      rdata_q <= i_rd ? rdata_mux : '0;
      irq_q <= |(status_d & mask_q);
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = irq_q;

endmodule

// ---- fifo_flag_pkg.sv ----
// Constants, register map and carrier types shared by the FIFO flag block
// and its storage array. Assumes a single 20 MHz system clock.
package fifo_flag_pkg;

  localparam int DATA_W = 9;
  localparam int DEPTH_DEFAULT = 16384;
  localparam int ADDR_W_DEFAULT = 14;
  localparam int OFFSET_LSB_W = 9;
  localparam int OFFSET_DEFAULT = 7;

  // Cycles the pin synchroniser needs to fill after reset release
  localparam logic [1:0] SYNC_FILL = 2'h3;

  localparam int CLK_PERIOD_NS = 50;

  // Register bus
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 32;
  localparam logic [BUS_AW-1:0] REG_STATUS = 8'h00;
  localparam logic [BUS_AW-1:0] REG_MASK = 8'h04;
  localparam logic [BUS_AW-1:0] REG_FLAGS = 8'h08;
  localparam logic [BUS_AW-1:0] REG_LEVEL = 8'h0C;
  localparam logic [BUS_AW-1:0] REG_OFFSETS = 8'h10;

  // Status and mask bit positions
  localparam int EVT_W = 6;
  localparam int EVT_FULL = 0;
  localparam int EVT_EMPTY = 1;
  localparam int EVT_ALMOST_FULL = 2;
  localparam int EVT_ALMOST_EMPTY = 3;
  localparam int EVT_WR_REFUSED = 4;
  localparam int EVT_RD_REFUSED = 5;
  localparam logic [EVT_W-1:0] MASK_RESET = 6'h00;

  // Flags register layout: flags in [3:0], load mode in bit 4
  localparam int FLG_FULL = 0;
  localparam int FLG_EMPTY = 1;
  localparam int FLG_ALMOST_FULL = 2;
  localparam int FLG_ALMOST_EMPTY = 3;
  localparam int FLG_LOAD_MODE = 4;

  // Offsets register: n in the low half, m in the high half
  localparam int OFFS_N_LSB = 0;
  localparam int OFFS_M_LSB = 16;

  // Order in which load-mode writes and reads walk the offset parts
  typedef enum logic [1:0] {
    PART_EMPTY_LO,
    PART_EMPTY_HI,
    PART_FULL_LO,
    PART_FULL_HI
  } offset_part_t;

  typedef struct packed {
    logic write_clock;
    logic write_enable_primary_n;
    logic write_enable_load_select;
    logic read_clock;
    logic read_enable_primary_n;
    logic read_enable_secondary_n;
    logic [DATA_W-1:0] write_data;
  } pin_in_t;

  // Active-low flags as seen on the pins
  typedef struct packed {
    logic almost_empty_n;
    logic almost_full_n;
    logic empty_n;
    logic full_n;
  } flags_t;

  localparam flags_t FLAGS_RESET = '{
    almost_empty_n: 1'b0,
    almost_full_n: 1'b1,
    empty_n: 1'b0,
    full_n: 1'b1
  };

endpackage

// ---- fifo_store.sv ----
// Simple dual-port storage array for the FIFO words.
// Assumes write and read addresses come from the same clock domain.
`timescale 1ns/1ps
module fifo_store
  import fifo_flag_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEFAULT,
  parameter int ADDR_W = ADDR_W_DEFAULT
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Write port
  input wire logic i_wr_en,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  // Read port
  input wire logic i_rd_en,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [DATA_W-1:0] o_rd_data
);

  logic [DATA_W-1:0] mem [DEPTH];

  // Array itself carries no reset so it can map onto block RAM
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= '0;
    end else if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule

// ---- fifo_flag_properties.sv ----
// Concurrent checks on the flag and data pins of the FIFO flag block.
// Assumes pin clocks reach the logic through a two-flop synchroniser, so a
// pin edge acts on the third i_clk edge after it.
`timescale 1ns/1ps
module fifo_flag_properties
  import fifo_flag_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Pin clocks and mode pin
  input wire logic i_write_clock,
  input wire logic i_read_clock,
  input wire logic i_write_enable_load_select,
  // Outputs watched
  input wire logic [DATA_W-1:0] o_read_data,
  input wire logic o_full_flag_n,
  input wire logic o_empty_flag_n,
  input wire logic o_almost_full_flag_n,
  input wire logic o_almost_empty_flag_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_full_wclk_only: assert property (
    $changed(o_full_flag_n) |-> $past(i_write_clock, 3) && !$past(i_write_clock, 4))
    else $error("full flag moved without a write clock edge");
  a_empty_rclk_only: assert property (
    $changed(o_empty_flag_n) |-> $past(i_read_clock, 3) && !$past(i_read_clock, 4))
    else $error("empty flag moved without a read clock edge");
  a_ae_rclk_only: assert property (
    $changed(o_almost_empty_flag_n) |-> $past(i_read_clock, 3) && !$past(i_read_clock, 4))
    else $error("almost empty flag moved without a read clock edge");
  a_af_wclk_only: assert property (
    $changed(o_almost_full_flag_n) |-> $past(i_write_clock, 3) && !$past(i_write_clock, 4))
    else $error("almost full flag moved without a write clock edge");
  a_empty_blocks_read: assert property (
    $past(i_read_clock, 2) && !$past(i_read_clock, 3) && !o_empty_flag_n
      && i_write_enable_load_select |=> $stable(o_read_data) [*3])
    else $error("read data changed on a read from an empty fifo");
  // Load reads answer one cycle earlier than array reads
  a_data_on_read: assert property (
    $changed(o_read_data) |-> ($past(i_read_clock, 4) && !$past(i_read_clock, 5))
      || ($past(i_read_clock, 3) && !$past(i_read_clock, 4)))
    else $error("read data changed without a read clock edge");
  a_empty_with_ae: assert property (
    !o_empty_flag_n |-> !o_almost_empty_flag_n)
    else $error("empty without almost empty");
  a_full_with_af: assert property (
    !o_full_flag_n |-> !o_almost_full_flag_n)
    else $error("full without almost full");
endmodule

bind fifo_flag_width_expansion fifo_flag_properties u_props (
  .i_clk(i_clk),
  .i_arst_n(i_arst_n),
  .i_write_clock(i_write_clock),
  .i_read_clock(i_read_clock),
  .i_write_enable_load_select(i_write_enable_load_select),
  .o_read_data(o_read_data),
  .o_full_flag_n(o_full_flag_n),
  .o_empty_flag_n(o_empty_flag_n),
  .o_almost_full_flag_n(o_almost_full_flag_n),
  .o_almost_empty_flag_n(o_almost_empty_flag_n)
);

// ---- fifo_pin_model.sv ----
// Writer and reader logic on the FIFO pins, one transfer per call.
// Assumes i_clk is the system clock; pin clocks rest low between transfers.
`timescale 1ns/1ps
module fifo_pin_model
  import fifo_flag_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Pins toward the FIFO
  output pin_in_t o_pins
);
  initial begin
    o_pins = '0;
    o_pins.write_enable_primary_n = 1'b1;
    o_pins.read_enable_primary_n = 1'b1;
    // Width expansion grounds the secondary read enable
    o_pins.read_enable_secondary_n = 1'b0;
  end

  task automatic select(input logic v);
    @(posedge i_clk);
    o_pins.write_enable_load_select <= v;
  endtask

  // Each pin clock phase lasts two system cycles, the slowest legal sampling
  task automatic cycle(input logic wr, input logic en_n, input logic lsel,
                       input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    o_pins.write_enable_load_select <= lsel;
    if (wr) begin
      o_pins.write_data <= d;
      o_pins.write_enable_primary_n <= en_n;
      o_pins.write_clock <= 1'b1;
    end else begin
      o_pins.read_enable_primary_n <= en_n;
      o_pins.read_clock <= 1'b1;
    end
    repeat (2) @(posedge i_clk);
    o_pins.write_clock <= 1'b0;
    o_pins.read_clock <= 1'b0;
    repeat (2) @(posedge i_clk);
    // Released data lines must not keep showing the old word
    o_pins.write_data <= ~d;
    o_pins.write_enable_primary_n <= 1'b1;
    o_pins.read_enable_primary_n <= 1'b1;
  endtask
endmodule

// ---- fifo_flag_width_expansion_tb.sv ----
// Self-checking bench: pin traffic through the pin model, registers
// through local tasks. Assumes DEPTH 1024 so filling stays short.
`timescale 1ns/1ps
module fifo_flag_width_expansion_tb;
  import fifo_flag_pkg::*;
  localparam int DEPTH = 1024;
  localparam logic [8:0] PARTS [5] = '{9'h005, 9'h000, 9'h00A, 9'h001, 9'h003};
  logic clk;
  logic arst_n;
  logic [BUS_AW-1:0] addr;
  logic [BUS_DW-1:0] wdata;
  logic wr;
  logic rd;
  logic [BUS_DW-1:0] rdata;
  logic [DATA_W-1:0] qdata;
  logic full_n;
  logic empty_n;
  logic af_n;
  logic ae_n;
  logic irq;
  pin_in_t pins;
  logic [BUS_DW-1:0] v;
  int failures;
  int total_checks;
  int w;
  int r;

  fifo_pin_model drv (.i_clk(clk), .o_pins(pins));

  fifo_flag_width_expansion #(.DEPTH(DEPTH), .ADDR_W(10)) dut (
    .i_clk(clk), .i_arst_n(arst_n),
    .i_write_clock(pins.write_clock),
    .i_write_enable_primary_n(pins.write_enable_primary_n),
    .i_write_enable_load_select(pins.write_enable_load_select),
    .i_write_data(pins.write_data),
    .i_read_clock(pins.read_clock),
    .i_read_enable_primary_n(pins.read_enable_primary_n),
    .i_read_enable_secondary_n(pins.read_enable_secondary_n),
    .o_read_data(qdata),
    .o_full_flag_n(full_n), .o_empty_flag_n(empty_n),
    .o_almost_full_flag_n(af_n), .o_almost_empty_flag_n(ae_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic reg_wr(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic expect_reg(input logic [BUS_AW-1:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(n, rdata, e);
  endtask

  task automatic do_reset(input logic lsel);
    drv.select(lsel);
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  task automatic push();
    drv.cycle(1'b1, 1'b0, 1'b1, w[DATA_W-1:0]);
    w++;
    #1;
  endtask

  task automatic pop();
    drv.cycle(1'b0, 1'b0, 1'b1, '0);
    repeat (2) @(posedge clk);
    #1 check("read data", qdata, r[DATA_W-1:0]);
    r++;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    complete_run();
  end

  initial begin
    arst_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    w = 0;
    r = 0;
    do_reset(1'b1);
    expect_reg(REG_FLAGS, 32'h05, "flags at reset");
    expect_reg(REG_OFFSETS, 32'h0007_0007, "default offsets");
    drv.cycle(1'b0, 1'b0, 1'b1, '0);
    expect_reg(REG_STATUS, 32'h20, "read refused event");
    check("refused read data", qdata, 32'h0);
    push();
    expect_reg(REG_FLAGS, 32'h05, "empty held until read");
    drv.cycle(1'b1, 1'b0, 1'b0, 9'h1AA);
    expect_reg(REG_LEVEL, 32'h1, "second enable low");
    repeat (8) push();
    // First read edge after writing only lifts the empty and almost-empty flags
    drv.cycle(1'b0, 1'b0, 1'b1, '0);
    pop();
    expect_reg(REG_FLAGS, 32'h0F, "above empty offset");
    pop();
    expect_reg(REG_FLAGS, 32'h07, "at empty offset");
    while (w - r < DEPTH) begin
      push();
      check("almost full", af_n, (w - r) < DEPTH - 7);
      check("full", full_n, (w - r) != DEPTH);
    end
    drv.cycle(1'b1, 1'b0, 1'b1, 9'h155);
    #1 check("full after refused", full_n, 32'h0);
    expect_reg(REG_LEVEL, DEPTH, "level after refused");
    while (r < w) begin
      pop();
      check("empty", empty_n, r != w);
    end
    expect_reg(REG_STATUS, 32'h3F, "all events");
    check("irq masked", irq, 32'h0);
    reg_wr(REG_MASK, 32'h3F);
    repeat (2) @(posedge clk);
    #1 check("irq unmasked", irq, 32'h1);
    expect_reg(REG_MASK, 32'h3F, "mask readback");
    reg_wr(REG_STATUS, 32'h3F);
    repeat (2) @(posedge clk);
    #1 check("irq cleared", irq, 32'h0);
    expect_reg(REG_STATUS, 32'h0, "status cleared");
    expect_reg(8'h20, 32'h0, "unmapped");
    do_reset(1'b0);
    r = w;
    expect_reg(REG_FLAGS, 32'h15, "load mode flags");
    for (int i = 0; i < 5; i++) drv.cycle(1'b1, 1'b0, 1'b0, PARTS[i]);
    expect_reg(REG_OFFSETS, 32'h020A_0003, "programmed offsets");
    drv.cycle(1'b0, 1'b0, 1'b0, '0);
    drv.cycle(1'b0, 1'b0, 1'b0, '0);
    #1 check("offset read", qdata, PARTS[2]);
    repeat (5) push();
    drv.cycle(1'b0, 1'b0, 1'b1, '0);
    pop();
    check("above programmed n", ae_n, 32'h1);
    pop();
    check("at programmed n", ae_n, 32'h0);
    complete_run();
  end
endmodule
